// *** rx_out_pkg.sv ***
// types and constants for the receive output interface
// assumes a single 100 MHz system clock samples every pin
package rx_out_pkg;

	// sampler depth for pins from outside the clock domain
	localparam int SYNC_STAGES = 2;

	// zeros in a row before loss of signal is declared
	localparam logic [5:0] LOS_ZERO_COUNT = 6'h20;

	// zeros before a violation counts as a substitution code
	localparam logic [1:0] SUBST_ZERO_RUN = 2'h2;

	// level on the mode pin that selects hardware control
	localparam logic MODE_HARDWARE = 1'b1;

	// reset values of the rail and loss outputs
	localparam logic RAIL_RESET = 1'b0;
	localparam logic LOS_RESET  = 1'b0;

	// one pair of rail bits, line side or framer side
	typedef struct packed {
		logic pos;
		logic neg;
	} rails_t;

	// internal configuration bits used in host mode
	typedef struct packed {
		logic mute;
		logic edge_falling;
	} rx_cfg_t;

endpackage

// *** sync_bits.sv ***
// two-flip-flop sampler for a group of pins
// assumes the pins are asynchronous to clk
`timescale 1ns/1ns
`default_nettype none
module sync_bits
	import rx_out_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] synced
);

	logic [W-1:0] meta;

	// first stage feeds only the second stage
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (rst) begin
					meta[i]   <= 1'b0;
					synced[i] <= 1'b0;
				end else begin
					meta[i]   <= pin[i];
					synced[i] <= meta[i];
				end
			end
		end
	endgenerate

endmodule
`default_nettype wire

// *** receive_output_interface.sv ***
// receive data, violation and loss-of-signal outputs toward a framer
// assumes the recovered clock and line pulses arrive as plain pins
// that clk (100 MHz) samples; the recovered clock is far slower
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - mode pin high or floating selects hardware
// - loss output high at least one cycle
// - loss output held while loss persists
// - violation pulse lasts exactly one receive cycle
// - ami mode flags every bipolar violation; the pulse pin shows it in single rail only
// - dual rail keeps pulse polarity per output
// - single rail gives nrz data
// - hardware mute forces rails low during loss
// - hardware mute off leaves data untouched
// - edge select picks the update edge
module receive_output_interface
	import rx_out_pkg::*;
(
	input  wire logic     clk,
	input  wire logic     rst,
	input  wire logic     recovered_clock,
	input  wire logic     line_in_positive,
	input  wire logic     line_in_negative,
	input  wire logic     control_mode_select,
	input  wire logic     rx_mute_select,
	input  wire logic     rx_clock_edge_select,
	input  wire logic     single_rail_select,
	input  wire logic     ami_select,
	input  wire rx_cfg_t  host_cfg,
	output logic          rx_clock_out,
	output logic          rx_positive_rail,
	output logic          rx_negative_rail,
	output logic          code_violation_pulse,
	output logic          loss_of_signal_out
);

	////////////////////////////////////////////////////////////////////
	// pin sampling

	logic [5:0] pins_s;
	logic       rclk_s;
	logic       rclk_prev;
	rails_t     line_s;
	logic       mode_s;
	logic       mute_pin_s;
	logic       edge_pin_s;

	sync_bits #(.W(6)) u_sync (
		.clk    (clk),
		.rst    (rst),
		.pin    ({recovered_clock, line_in_positive, line_in_negative,
		          control_mode_select, rx_mute_select,
		          rx_clock_edge_select}),
		.synced (pins_s)
	);

	// named views of the sampled pins
	assign rclk_s     = pins_s[5];
	assign line_s     = '{pos: pins_s[4], neg: pins_s[3]};
	assign mode_s     = pins_s[2];
	assign mute_pin_s = pins_s[1];
	assign edge_pin_s = pins_s[0];

	////////////////////////////////////////////////////////////////////
	// option selection and clock edges

	logic hw_mode;
	logic mute_on;
	logic edge_on;
	logic rise;
	logic fall;
	logic upd;

	// a floating mode pin reads high through its pull-up
	assign hw_mode = (mode_s == MODE_HARDWARE);
	assign mute_on = hw_mode ? mute_pin_s : host_cfg.mute;
	assign edge_on = hw_mode ? edge_pin_s : host_cfg.edge_falling;
	assign rise    = rclk_s & ~rclk_prev;
	assign fall    = ~rclk_s & rclk_prev;
	assign upd     = edge_on ? fall : rise;

	// previous recovered clock level for edge finding
	always_ff @(posedge clk) begin
		if (rst) begin
			rclk_prev <= 1'b0;
		end else begin
			rclk_prev <= rclk_s;
		end
	end

	////////////////////////////////////////////////////////////////////
	// line decoding, done at each rising recovered clock edge

	logic       mark;
	logic       last_pol;
	logic       have_mark;
	logic       bpv;
	logic       subst_ok;
	logic [1:0] zero_run;
	logic [5:0] zero_cnt;
	logic [1:0] next_zero_run;
	logic [5:0] next_zero_cnt;
	rails_t     stage_rails;
	logic       stage_nrz;
	logic       stage_cv;
	logic       stage_los;

	// a mark on both rails at once is itself a violation
	assign mark     = line_s.pos | line_s.neg;
	assign bpv      = mark & have_mark & (line_s.pos == last_pol);
	// outside ami mode, a violation after two or more zeros is a substitution
	assign subst_ok = ~ami_select & (zero_run >= SUBST_ZERO_RUN);
	assign next_zero_run = mark ? 2'h0
		: ((zero_run == 2'h3) ? zero_run : zero_run + 2'h1);
	assign next_zero_cnt = mark ? 6'h00
		: ((zero_cnt == LOS_ZERO_COUNT) ? zero_cnt : zero_cnt + 6'h01);

	// decoder state and staged values for the output edge
	always_ff @(posedge clk) begin
		if (rst) begin
			last_pol    <= 1'b0;
			have_mark   <= 1'b0;
			zero_run    <= 2'h0;
			zero_cnt    <= 6'h00;
			stage_rails <= '0;
			stage_nrz   <= 1'b0;
			stage_cv    <= 1'b0;
			stage_los   <= LOS_RESET;
		end else if (rise) begin
			if (mark) begin
				last_pol  <= line_s.pos;
				have_mark <= 1'b1;
			end
			zero_run    <= next_zero_run;
			zero_cnt    <= next_zero_cnt;
			stage_rails <= line_s;
			stage_nrz   <= mark & ~(bpv & subst_ok);
			stage_cv    <= (bpv & ~subst_ok)
				| (line_s.pos & line_s.neg);
			stage_los   <= (next_zero_cnt == LOS_ZERO_COUNT);
		end
	end

	////////////////////////////////////////////////////////////////////
	// framer-side outputs; all but the forwarded clock updated on the selected edge

	logic   muted;
	rails_t rail_data;
	rails_t next_rails;

	assign muted      = mute_on & stage_los;
	assign rail_data  = single_rail_select
		? '{pos: stage_nrz, neg: RAIL_RESET} : stage_rails;
	assign next_rails = muted ? '{pos: RAIL_RESET, neg: RAIL_RESET}
		: rail_data;

	// rail, violation and loss outputs change only on an update edge, so each lasts a cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_clock_out         <= 1'b0;
			rx_positive_rail     <= RAIL_RESET;
			rx_negative_rail     <= RAIL_RESET;
			code_violation_pulse <= 1'b0;
			loss_of_signal_out   <= LOS_RESET;
		end else begin
			rx_clock_out <= rclk_s;
			if (upd) begin
				rx_positive_rail     <= next_rails.pos;
				rx_negative_rail     <= next_rails.neg;
				code_violation_pulse <= single_rail_select & stage_cv;
				loss_of_signal_out   <= stage_los;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_update_edge;
		upd;
	endsequence

	sequence s_loss_staged;
		upd && stage_los;
	endsequence

	property p_mode_select;
		hw_mode |-> (mute_on == mute_pin_s) && (edge_on == edge_pin_s);
	endproperty
	a_mode_select: assert property (p_mode_select)
		else $error("hardware mode ignores option pins");

	property p_host_cfg;
		!hw_mode |-> (mute_on == host_cfg.mute)
			&& (edge_on == host_cfg.edge_falling);
	endproperty
	a_host_cfg: assert property (p_host_cfg)
		else $error("host mode ignores configuration bits");

	property p_loss_min;
		$fell(loss_of_signal_out) || $rose(loss_of_signal_out)
			|-> $past(upd);
	endproperty
	a_loss_min: assert property (p_loss_min)
		else $error("loss output changed off an update edge");

	property p_loss_hold;
		s_loss_staged |=> loss_of_signal_out;
	endproperty
	a_loss_hold: assert property (p_loss_hold)
		else $error("loss output dropped while loss persists");

	property p_cv_width;
		code_violation_pulse && !upd |=> code_violation_pulse;
	endproperty
	a_cv_width: assert property (p_cv_width)
		else $error("violation pulse shorter than a receive cycle");

	property p_cv_clear;
		s_update_edge ##0 !stage_cv |=> !code_violation_pulse;
	endproperty
	a_cv_clear: assert property (p_cv_clear)
		else $error("violation pulse longer than a receive cycle");

	// second half of the violation path: staged flag reaches the pin
	property p_ami_bpv;
		s_update_edge ##0 (single_rail_select && stage_cv)
			|=> code_violation_pulse;
	endproperty
	a_ami_bpv: assert property (p_ami_bpv)
		else $error("staged violation missing on the pulse output");

	property p_ami_bpv_staged;
		rise && ami_select && bpv |=> stage_cv;
	endproperty
	a_ami_bpv_staged: assert property (p_ami_bpv_staged)
		else $error("bipolar violation not flagged in ami mode");

	property p_dual_rail;
		upd && !single_rail_select && !muted |=>
			(rx_positive_rail == $past(stage_rails.pos))
			&& (rx_negative_rail == $past(stage_rails.neg));
	endproperty
	a_dual_rail: assert property (p_dual_rail)
		else $error("dual rail outputs lost polarity");

	property p_single_rail;
		upd && single_rail_select && !muted |=>
			(rx_positive_rail == $past(stage_nrz)) && !rx_negative_rail;
	endproperty
	a_single_rail: assert property (p_single_rail)
		else $error("single rail data not nrz");

	property p_mute;
		upd && hw_mode && mute_pin_s && stage_los |=>
			!rx_positive_rail && !rx_negative_rail;
	endproperty
	a_mute: assert property (p_mute)
		else $error("rails not muted during loss");

	property p_no_mute;
		upd && hw_mode && !mute_pin_s && !single_rail_select |=>
			(rx_positive_rail == $past(stage_rails.pos));
	endproperty
	a_no_mute: assert property (p_no_mute)
		else $error("rails muted with muting disabled");

	property p_edge;
		$changed(loss_of_signal_out) || $changed(rx_positive_rail)
			|-> $past(edge_on ? fall : rise);
	endproperty
	a_edge: assert property (p_edge)
		else $error("output updated on the wrong edge");

endmodule
`default_nettype wire

// *** framer_model.sv ***
// framer stand-in that captures the receive outputs once per bit
// assumes edge_falling tracks the update edge the device is using
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////
module framer_model
	import rx_out_pkg::*;
(
	input  wire logic       rx_clock_out,
	input  wire logic       edge_falling,
	input  wire rails_t     rails,
	input  wire logic       violation,
	input  wire logic       loss,
	output var  logic [3:0] got
);
	// sample on the edge opposite the update so the data has settled
	always @(rx_clock_out) begin
		if (rx_clock_out == edge_falling)
			got <= {rails, violation, loss};
	end
endmodule
`default_nettype wire

// *** receive_output_interface_tb_top.sv ***
// bench: plays line symbols bit by bit and checks outputs and framer view
// assumes a 160 ns recovered clock made here and a 10 ns system clock
`timescale 1ns/1ns
`default_nettype none
`define CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
	fail_count++; $display("unexpected at %0t: got %b want %b", \
	$time, got, exp); end end
////////////////////////////////////////
module receive_output_interface_tb_top
	import rx_out_pkg::*;
;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       rclk = 1'b0;
	rails_t     line = 2'h0;
	logic       mode = 1'b1;
	logic       mute = 1'b0;
	logic       edge_sel = 1'b1;
	logic       single = 1'b0;
	logic       ami = 1'b1;
	rx_cfg_t    cfg = 2'h0;
	logic       rxc, rp, rn, cv, los, eff_fall;
	logic [3:0] got, pend;
	logic       armed = 1'b0;
	rails_t     last_mark = 2'h0;
	int         zeros = 0;
	int         fail_count = 0;
	int         checks_done = 0;

	always #5 clk = ~clk;
	// the framer must follow whichever edge option is in force
	assign eff_fall = mode ? edge_sel : cfg.edge_falling;

	receive_output_interface receive_output_interface_inst (
		.clk(clk), .rst(rst), .recovered_clock(rclk),
		.line_in_positive(line.pos), .line_in_negative(line.neg),
		.control_mode_select(mode), .rx_mute_select(mute),
		.rx_clock_edge_select(edge_sel), .single_rail_select(single),
		.ami_select(ami), .host_cfg(cfg), .rx_clock_out(rxc),
		.rx_positive_rail(rp), .rx_negative_rail(rn),
		.code_violation_pulse(cv), .loss_of_signal_out(los));
	framer_model framer_model_inst (.rx_clock_out(rxc),
		.edge_falling(eff_fall), .rails({rp, rn}), .violation(cv),
		.loss(los), .got(got));

	////////////////////////////////////////
	// one recovered cycle; expectation derived from the line symbol
	task automatic step(input rails_t b);
		logic [3:0] e;
		logic       v;
		logic       sub;
		v = (b == 2'h3) || (b != 2'h0 && b == last_mark);
		sub = v && !ami && zeros >= 2;
		if (b != 2'h0)
			last_mark = (b == 2'h3) ? 2'h2 : b;
		zeros = (b == 2'h0) ? zeros + 1 : 0;
		e = single ? {|b && !sub, 1'b0, v && !sub, 1'b0} : {b, 2'h0};
		e[0] = zeros >= 32;
		line <= b;
		rclk <= 1'b1;
		repeat (8) @(posedge clk);
		// the forwarded clock trails the pin by a few system cycles
		`CHECK(rxc, 1'b1)
		rclk <= 1'b0;
		repeat (8) @(posedge clk);
		// framer lags one bit; rising update also lags at the pins
		`CHECK(rxc, 1'b0)
		if (armed)
			`CHECK(got, pend)
		if (armed || eff_fall)
			`CHECK({rp, rn, cv, los}, eff_fall ? e : pend)
		pend = e;
		armed = 1'b1;
	endtask

	// symbols packed two bits each, first symbol in the low bits
	task automatic play(input logic [15:0] s, input int n);
		for (int i = 0; i < n; i++)
			step(s[2*i +: 2]);
		$display("test pattern %h done", s);
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	////////////////////////////////////////
	// 74 bits of 16 cycles each; over eight times that means a hang
	initial begin
		#100000;
		fail_count++;
		close_out();
	end

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		`CHECK({rp, rn, cv, los}, 4'h0)
		play(16'h0692, 6);
		single <= 1'b1;
		play(16'h2852, 7);
		ami <= 1'b0;
		play(16'h0582, 6);
		single <= 1'b0;
		edge_sel <= 1'b0;
		armed = 1'b0;
		play(16'h0692, 6);
		mode <= 1'b0;
		// host edge bit set; host mute set too, but this pattern never reaches loss
		cfg <= 2'h3;
		armed = 1'b0;
		play(16'h0692, 6);
		mode <= 1'b1;
		edge_sel <= 1'b1;
		mute <= 1'b1;
		armed = 1'b0;
		repeat (5) play(16'h0000, 8);
		mute <= 1'b0;
		play(16'h0012, 3);
		close_out();
	end
endmodule
`default_nettype wire
